// >>> src/lb_decode_params.svh
`ifndef LB_DECODE_PARAMS_SVH
`define LB_DECODE_PARAMS_SVH

// mode pin codes
`define MODE_PINS_LB8      2'h0
`define MODE_PINS_PARPORT  2'h1
`define MODE_PINS_LB32     2'h2

// fields of the local bus configuration word
`define CFG_IO_SIZE_LSB    20
`define CFG_IO_SIZE_W      3
`define CFG_CS_BIT_LSB     23
`define CFG_CS_BIT_W       4
`define CFG_MEM_SIZE_LSB   27
`define CFG_MEM_SIZE_W     2

// i/o block size limits, as log2 of bytes, and the highest i/o decode bit
`define IO_LOG2_MIN        4'h2
`define IO_LOG2_MAX        4'h8
`define CS_BIT_MAX         4'h8
// memory decode bit is offset from the configured code by this much
`define MEM_CS_BIT_OFFSET  5'h04

// fixed window masks (address bits that lie inside the window) and the 16K memory size code
`define MASK_4K            32'h0000_0FFF
`define MASK_16K           32'h0000_3FFF
`define MASK_8B            32'h0000_0007
`define MEM_SIZE_16K       2'h1

// reset values of registered outputs
`define ADDR_RESET         12'h000
`define SELECT_IDLE        4'hF

`endif

// >>> src/lb_decode_pkg.sv
package lb_decode_pkg;

   // function chosen by the mode pins
   typedef enum logic [1:0] {
      FUNC_LB8,
      FUNC_LB32,
      FUNC_PARPORT
   } func_type;

   // address space of a pci access
   typedef enum logic [1:0] {
      SPACE_NONE,
      SPACE_IO,
      SPACE_MEM
   } space_type;

endpackage

// >>> src/local_bus_decoder.sv
// Overview of operation
// - i/o window size configurable 4..256 bytes
// - two adjacent bits decode four i/o selects
// - 8-bit mode: address lines copy pci bits
// - lines above small i/o block read zero
// - select number equals two decode bits
// - upper decode bit outside block: two selects
// - both bits outside block: select 0 only
// - 8-bit memory window fixed 4K, dword only
// - 8-bit memory: pci bits 9:2 on lines
// - 8-bit memory selects from pci bits 11:10
// - strobe style turns selects into strobes
// - 32-bit mode: twelve address lines
// - 32-bit mode: pci bits 13:2 on lines
// - 32-bit memory window 4K or 16K
// - 32-bit memory honours configured decode bit
// - parallel port: two i/o windows, no memory
// - port base window size from config bits
// - port extended window fixed 8 bytes
// - local bus: window 0 i/o, window 1 memory
`include "lb_decode_params.svh"
`timescale 1ns/100ps
`default_nettype none

module local_bus_decoder
   import lb_decode_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // configuration
   input  wire logic [1:0]  mode_pins_i,
   input  wire logic        strobe_style_i,
   input  wire logic [31:0] local_bus_config_word_i,
   // window bases assigned by the host
   input  wire logic [31:0] bar0_base_i,
   input  wire logic [31:0] bar1_base_i,
   // pci access in progress
   input  wire logic        access_active_i,
   input  wire logic        access_io_i,
   input  wire logic        access_mem_i,
   input  wire logic [31:0] pci_addr_i,
   // window sizes requested from the host
   output logic      [31:0] bar0_size_mask_o,
   output logic      [31:0] bar1_size_mask_o,
   output logic             bar1_is_io_o,
   // hit indications
   output logic             lb_cycle_o,
   output logic             port_base_hit_o,
   output logic             port_ext_hit_o,
   // local bus
   output logic      [11:0] local_addr_lines_o,
   output logic             local_select0_n_o,
   output logic             local_select1_n_o,
   output logic             local_select2_n_o,
   output logic             local_select3_n_o,
   output logic             local_strobe0_n_o,
   output logic             local_strobe1_n_o,
   output logic             local_strobe2_n_o,
   output logic             local_strobe3_n_o
);

   // mask of address bits inside a window of 2**log2 bytes
   function automatic logic [31:0] log2_mask(input logic [3:0] log2);
      log2_mask = (32'h0000_0001 << log2) - 32'h0000_0001;
   endfunction

   // true when the address falls in the window at base
   function automatic logic in_window(input logic [31:0] addr,
                                      input logic [31:0] base,
                                      input logic [31:0] mask);
      in_window = ((addr ^ base) & ~mask) == 32'h0000_0000;
   endfunction

   // two decode bits starting at bit lo of an in-window offset
   function automatic logic [1:0] pick_select(input logic [31:0] off,
                                              input logic [4:0]  lo);
      logic [31:0] shifted;
      shifted = off >> lo;
      pick_select = shifted[1:0];
   endfunction

   // route the active-low vector to one pin set, the other idles high
   function automatic logic [3:0] route_pins(input logic [3:0] vec_n,
                                             input logic       use_set);
      route_pins = use_set ? vec_n : `SELECT_IDLE;
   endfunction

   // function selected by the mode pins
   func_type func;
   assign func = (mode_pins_i == `MODE_PINS_PARPORT) ? FUNC_PARPORT :
                 (mode_pins_i == `MODE_PINS_LB32)    ? FUNC_LB32 :
                                                       FUNC_LB8;

   wire logic is_lb32 = (func == FUNC_LB32);
   wire logic is_port = (func == FUNC_PARPORT);

   // space of the current access
   space_type space;
   assign space = access_io_i  ? SPACE_IO  :
                  access_mem_i ? SPACE_MEM : SPACE_NONE;

   // configuration fields
   wire logic [2:0] cfg_io_size =
      local_bus_config_word_i[`CFG_IO_SIZE_LSB +: `CFG_IO_SIZE_W];
   wire logic [3:0] cfg_cs_bit =
      local_bus_config_word_i[`CFG_CS_BIT_LSB +: `CFG_CS_BIT_W];
   wire logic [1:0] cfg_mem_size =
      local_bus_config_word_i[`CFG_MEM_SIZE_LSB +: `CFG_MEM_SIZE_W];

   // i/o block log2 size: code n gives 2**(n+1) bytes, code 0 raised to 4, 4..256
   wire logic [3:0] io_log2_raw = {1'b0, cfg_io_size} + 4'h1;
   wire logic [3:0] io_log2 =
      (io_log2_raw < `IO_LOG2_MIN) ? `IO_LOG2_MIN :
      (io_log2_raw > `IO_LOG2_MAX) ? `IO_LOG2_MAX : io_log2_raw;
   wire logic [31:0] io_mask = log2_mask(io_log2);

   // memory window size for each local bus width
   wire logic [31:0] mem_mask =
      (is_lb32 && cfg_mem_size == `MEM_SIZE_16K) ?
      `MASK_16K : `MASK_4K;

   // requested window sizes
   wire logic [31:0] bar0_mask = io_mask;
   wire logic [31:0] bar1_mask =
      is_port ? `MASK_8B : mem_mask;

   // window hits
   wire logic io_space  = (space == SPACE_IO);
   wire logic mem_space = (space == SPACE_MEM);
   wire logic bar0_hit =
      io_space && in_window(pci_addr_i, bar0_base_i, bar0_mask);
   wire logic bar1_hit_io =
      io_space && is_port && in_window(pci_addr_i, bar1_base_i, bar1_mask);
   wire logic bar1_hit_mem =
      mem_space && !is_port &&
      in_window(pci_addr_i, bar1_base_i, bar1_mask);

   // local bus cycles: window 0 by i/o, window 1 by memory
   wire logic lb_io_hit  = bar0_hit && !is_port;
   wire logic lb_mem_hit = bar1_hit_mem;
   wire logic lb_hit = access_active_i && (lb_io_hit || lb_mem_hit);

   // offsets within each window
   wire logic [31:0] io_off  = pci_addr_i & io_mask;
   wire logic [31:0] mem_off = pci_addr_i & mem_mask;

   // lowest decode bit, never above bit 8 for i/o
   wire logic [3:0] io_cs_bit =
      (cfg_cs_bit > `CS_BIT_MAX) ? `CS_BIT_MAX : cfg_cs_bit;
   wire logic [4:0] mem32_cs_bit =
      {1'b0, cfg_cs_bit} + `MEM_CS_BIT_OFFSET;

   // i/o select: decode bits beyond the block read zero
   wire logic [1:0] io_select =
      pick_select(io_off, {1'b0, io_cs_bit});

   // memory select: fixed bits 11:10 in 8-bit mode
   wire logic [1:0] mem8_select  = pci_addr_i[11:10];
   wire logic [1:0] mem32_select = pick_select(mem_off, mem32_cs_bit);
   wire logic [1:0] mem_select =
      is_lb32 ? mem32_select : mem8_select;

   wire logic [1:0] select_num =
      lb_io_hit ? io_select : mem_select;

   // address lines for each width and space
   wire logic [11:0] io8_lines  = {4'h0, io_off[7:0]};
   wire logic [11:0] mem8_lines = {4'h0, pci_addr_i[9:2]};
   // 32-bit memory lines carry the raw pci bits, even in a 4K window
   wire logic [11:0] io32_lines  = io_off[13:2];
   wire logic [11:0] mem32_lines = pci_addr_i[13:2];
   wire logic [11:0] lines32 =
      lb_io_hit ? io32_lines : mem32_lines;
   wire logic [11:0] lines8 =
      lb_io_hit ? io8_lines : mem8_lines;
   wire logic [11:0] next_addr_lines =
      is_lb32 ? lines32 : lines8;

   // one-hot active-low select vector, idle unless a hit
   wire logic [3:0] select_onehot = 4'h1 << select_num;
   wire logic [3:0] next_select_n =
      lb_hit ? ~select_onehot : `SELECT_IDLE;

   // the chosen signalling style routes the vector to one pin set
   wire logic [3:0] next_cs_n = route_pins(next_select_n, !strobe_style_i);
   wire logic [3:0] next_ds_n =
      route_pins(next_select_n, strobe_style_i);

   // port window hits
   wire logic next_port_base = access_active_i && bar0_hit && is_port;
   wire logic next_port_ext  = access_active_i && bar1_hit_io;

   // registered chip selects, idle high
   logic [3:0] cs_n;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cs_n <= `SELECT_IDLE;
      end else begin
         cs_n <= next_cs_n;
      end
   end

   // registered data strobes, idle high
   logic [3:0] ds_n;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ds_n <= `SELECT_IDLE;
      end else begin
         ds_n <= next_ds_n;
      end
   end

   // registered address lines, held between accesses
   logic [11:0] addr_lines;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         addr_lines <= `ADDR_RESET;
      end else if (lb_hit) begin
         addr_lines <= next_addr_lines;
      end
   end

   // registered local bus cycle flag
   logic lb_cycle;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         lb_cycle <= 1'b0;
      end else begin
         lb_cycle <= lb_hit;
      end
   end

   // registered port base window hit
   logic port_base;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         port_base <= 1'b0;
      end else begin
         port_base <= next_port_base;
      end
   end

   // registered port extended window hit
   logic port_ext;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         port_ext <= 1'b0;
      end else begin
         port_ext <= next_port_ext;
      end
   end

   // window 0 size request, following the i/o size field
   logic [31:0] bar0_size;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bar0_size <= `MASK_8B;
      end else begin
         bar0_size <= bar0_mask;
      end
   end

   // window 1 size request, per function, 4K or 16K by the memory size field in 32-bit mode
   logic [31:0] bar1_size;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bar1_size <= `MASK_4K;
      end else begin
         bar1_size <= bar1_mask;
      end
   end

   // window 1 space: i/o only for the parallel port
   logic bar1_io;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bar1_io <= 1'b0;
      end else begin
         bar1_io <= is_port;
      end
   end

   // window size and hit outputs
   assign bar0_size_mask_o   = bar0_size;
   assign bar1_size_mask_o   = bar1_size;
   assign bar1_is_io_o       = bar1_io;
   assign lb_cycle_o         = lb_cycle;
   assign port_base_hit_o    = port_base;
   assign port_ext_hit_o     = port_ext;

   // local bus pins
   assign local_addr_lines_o = addr_lines;
   assign local_select0_n_o  = cs_n[0];
   assign local_select1_n_o  = cs_n[1];
   assign local_select2_n_o  = cs_n[2];
   assign local_select3_n_o  = cs_n[3];
   assign local_strobe0_n_o  = ds_n[0];
   assign local_strobe1_n_o  = ds_n[1];
   assign local_strobe2_n_o  = ds_n[2];
   assign local_strobe3_n_o  = ds_n[3];

endmodule

`default_nettype wire

// >>> tb/local_bus_decoder_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "lb_decode_params.svh"
module local_bus_decoder_checker (
   // clock, reset and setup
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic [1:0]  mode_pins_i,
   input wire logic        strobe_style_i,
   input wire logic [31:0] local_bus_config_word_i,
   input wire logic [31:0] bar1_base_i,
   // access
   input wire logic        access_active_i,
   input wire logic        access_io_i,
   input wire logic        access_mem_i,
   input wire logic [31:0] pci_addr_i,
   // outputs watched
   input wire logic [31:0] bar0_size_mask_o,
   input wire logic [31:0] bar1_size_mask_o,
   input wire logic        lb_cycle_o,
   input wire logic [11:0] local_addr_lines_o,
   input wire logic        local_select0_n_o,
   input wire logic        local_select1_n_o,
   input wire logic        local_select2_n_o,
   input wire logic        local_select3_n_o,
   input wire logic        local_strobe0_n_o,
   input wire logic        local_strobe1_n_o,
   input wire logic        local_strobe2_n_o,
   input wire logic        local_strobe3_n_o
);
   // pin vectors, mode and window decode
   wire logic [3:0]  sel_n = {local_select3_n_o, local_select2_n_o, local_select1_n_o,
                              local_select0_n_o};
   wire logic [3:0]  stb_n = {local_strobe3_n_o, local_strobe2_n_o, local_strobe1_n_o,
                              local_strobe0_n_o};
   wire logic        lb32 = mode_pins_i == `MODE_PINS_LB32;
   wire logic        lb8 = !lb32 && mode_pins_i != `MODE_PINS_PARPORT;
   wire logic [2:0]  size_code = local_bus_config_word_i[22:20];
   wire logic [31:0] io_mask = (size_code == 3'h0) ? 32'h0000_0003 :
                               (32'h0000_0002 << size_code) - 32'h0000_0001;
   wire logic [31:0] mem_mask = (lb32 && local_bus_config_word_i[28:27] == 2'h1) ?
                                32'h0000_3FFF : 32'h0000_0FFF;
   wire logic        mem_hit = access_active_i && !access_io_i && access_mem_i &&
                               ((pci_addr_i ^ bar1_base_i) & ~mem_mask) == 32'h0000_0000;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_one_active: assert property (
      $onehot0(~{sel_n, stb_n}))
      else $error("several selects or strobes low");
   a_idle_release: assert property (
      !access_active_i |=> &{sel_n, stb_n} && !lb_cycle_o)
      else $error("select low without access");
   a_port_quiet: assert property (
      !lb32 && !lb8 |=> &{sel_n, stb_n} && !lb_cycle_o)
      else $error("local bus cycle in port mode");
   a_mem8_lines: assert property (
      lb8 && mem_hit |=> local_addr_lines_o == {4'h0, $past(pci_addr_i[9:2])})
      else $error("memory address lines wrong");
   a_mem8_select: assert property (
      lb8 && mem_hit && !strobe_style_i |=>
      sel_n == ~(4'h1 << $past(pci_addr_i[11:10])))
      else $error("memory select wrong");
   a_mem32_lines: assert property (
      lb32 && mem_hit |=> local_addr_lines_o == $past(pci_addr_i[13:2]))
      else $error("wide address lines wrong");
   a_io_window_size: assert property (
      !sys_rst_i |=> bar0_size_mask_o == $past(io_mask))
      else $error("io window size wrong");
   a_ext_window_size: assert property (
      !lb32 && !lb8 |=> bar1_size_mask_o == 32'h0000_0007)
      else $error("extended window size wrong");
endmodule
bind local_bus_decoder local_bus_decoder_checker local_bus_decoder_checker_inst (.sys_clk_i,
   .sys_rst_i, .mode_pins_i, .strobe_style_i, .local_bus_config_word_i, .bar1_base_i,
   .access_active_i, .access_io_i, .access_mem_i, .pci_addr_i, .bar0_size_mask_o,
   .bar1_size_mask_o, .lb_cycle_o, .local_addr_lines_o, .local_select0_n_o, .local_select1_n_o,
   .local_select2_n_o, .local_select3_n_o, .local_strobe0_n_o, .local_strobe1_n_o,
   .local_strobe2_n_o, .local_strobe3_n_o);
`default_nettype wire

// >>> tb/pci_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pci_host_model (
   // clock
   input  wire logic        sys_clk_i,
   // target access and window bases
   output logic             access_active_o,
   output logic             access_io_o,
   output logic             access_mem_o,
   output logic      [31:0] pci_addr_o,
   output logic      [31:0] bar0_base_o,
   output logic      [31:0] bar1_base_o
);
   // idle bus at start
   initial begin
      access_active_o = 1'b0;
      access_io_o = 1'b0;
      access_mem_o = 1'b0;
      pci_addr_o = 32'hA5A5_A5A5;
      bar0_base_o = 32'h0000_0000;
      bar1_base_o = 32'h0000_0000;
   end
   // window placement; port extension sits above the base window
   task automatic place(input logic port, input logic [31:0] b0, input logic [31:0] b1);
      @(posedge sys_clk_i);
      bar0_base_o <= b0;
      bar1_base_o <= port ? b0 + 32'h0000_0400 : b1;
   endtask
   // one-cycle access, then a released address shows the inverse
   task automatic access(input logic io, input logic [31:0] a);
      @(posedge sys_clk_i);
      access_active_o <= 1'b1;
      access_io_o <= io;
      access_mem_o <= !io;
      pci_addr_o <= a;
      @(posedge sys_clk_i);
      access_active_o <= 1'b0;
      access_io_o <= 1'b0;
      access_mem_o <= 1'b0;
      pci_addr_o <= ~a;
   endtask
endmodule
`default_nettype wire

// >>> tb/test_local_bus_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "lb_decode_params.svh"
module test_local_bus_decoder;
   // stimulus and observed outputs
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [1:0]  mode = 2'h0;
   logic        style = 1'b0;
   logic [31:0] cfg = 32'h0000_0000;
   wire logic        act, io, mem, isio, lbc, ph, pe;
   wire logic [31:0] addr, b0, b1, m0, m1;
   wire logic [11:0] la;
   wire logic [3:0]  sel, stb;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   pci_host_model pci_host_model_inst (.sys_clk_i(sys_clk_i), .access_active_o(act),
      .access_io_o(io), .access_mem_o(mem), .pci_addr_o(addr), .bar0_base_o(b0),
      .bar1_base_o(b1));
   local_bus_decoder local_bus_decoder_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .mode_pins_i(mode), .strobe_style_i(style), .local_bus_config_word_i(cfg),
      .bar0_base_i(b0), .bar1_base_i(b1), .access_active_i(act), .access_io_i(io),
      .access_mem_i(mem), .pci_addr_i(addr), .bar0_size_mask_o(m0), .bar1_size_mask_o(m1),
      .bar1_is_io_o(isio), .lb_cycle_o(lbc), .port_base_hit_o(ph), .port_ext_hit_o(pe),
      .local_addr_lines_o(la), .local_select0_n_o(sel[0]), .local_select1_n_o(sel[1]),
      .local_select2_n_o(sel[2]), .local_select3_n_o(sel[3]), .local_strobe0_n_o(stb[0]),
      .local_strobe1_n_o(stb[1]), .local_strobe2_n_o(stb[2]), .local_strobe3_n_o(stb[3]));
   // compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // new mode, style and config word; masks settle one edge later
   task automatic setup(input logic [1:0] m, input logic s, input logic [2:0] sz,
                        input logic [3:0] cs, input logic [1:0] msz);
      @(posedge sys_clk_i);
      mode <= m;
      style <= s;
      cfg <= {3'h0, msz, cs, sz, 20'h0_0000};
      @(posedge sys_clk_i);
      #1;
   endtask
   // one access; pins and lines are looked at one edge later
   task automatic hit(input logic is_io, input logic [31:0] a, input logic [3:0] esel,
                      input logic [11:0] eaddr);
      pci_host_model_inst.access(is_io, a);
      #1;
      check("pins", {24'h0, sel, stb},
            style ? {24'h0, 4'hF, esel} : {24'h0, esel, 4'hF});
      check("cycle", {31'h0, lbc}, {31'h0, esel != 4'hF});
      if (esel != 4'hF) check("lines", {20'h0, la}, {20'h0, eaddr});
   endtask
   // hang guard
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      pci_host_model_inst.place(1'b0, 32'h0000_10E0, 32'h8000_0000);
      setup(`MODE_PINS_LB8, 1'b0, 3'h4, 4'h3, 2'h0);
      check("io mask", m0, 32'h0000_001F);
      check("mem mask", m1, 32'h0000_0FFF);
      check("ext io", {31'h0, isio}, 32'h0000_0000);
      hit(1'b1, 32'h0000_10E0, 4'hE, 12'h000);
      hit(1'b1, 32'h0000_10EB, 4'hD, 12'h00B);
      hit(1'b1, 32'h0000_10F3, 4'hB, 12'h013);
      hit(1'b1, 32'h0000_10FF, 4'h7, 12'h01F);
      hit(1'b1, 32'h0000_2000, 4'hF, 12'h000);
      hit(1'b0, 32'h8000_0C0C, 4'h7, 12'h003);
      hit(1'b0, 32'h8000_07FC, 4'hD, 12'h0FF);
      hit(1'b0, 32'h8000_1000, 4'hF, 12'h000);
      setup(`MODE_PINS_LB8, 1'b0, 3'h4, 4'h4, 2'h0);
      hit(1'b1, 32'h0000_10EF, 4'hE, 12'h00F);
      hit(1'b1, 32'h0000_10F0, 4'hD, 12'h010);
      setup(`MODE_PINS_LB8, 1'b0, 3'h4, 4'h5, 2'h0);
      hit(1'b1, 32'h0000_10FF, 4'hE, 12'h01F);
      setup(`MODE_PINS_LB8, 1'b0, 3'h7, 4'h6, 2'h0);
      check("io mask", m0, 32'h0000_00FF);
      hit(1'b1, 32'h0000_10C5, 4'h7, 12'h0C5);
      setup(`MODE_PINS_LB8, 1'b1, 3'h4, 4'h3, 2'h0);
      hit(1'b0, 32'h8000_0800, 4'hB, 12'h000);
      setup(`MODE_PINS_LB32, 1'b0, 3'h4, 4'h8, 2'h1);
      check("mem mask", m1, 32'h0000_3FFF);
      hit(1'b0, 32'h8000_3004, 4'h7, 12'hC01);
      setup(`MODE_PINS_LB32, 1'b0, 3'h4, 4'h6, 2'h0);
      check("mem mask", m1, 32'h0000_0FFF);
      hit(1'b0, 32'h8000_0C08, 4'h7, 12'h302);
      pci_host_model_inst.place(1'b1, 32'h0000_0378, 32'h0000_0000);
      setup(`MODE_PINS_PARPORT, 1'b0, 3'h1, 4'h3, 2'h0);
      check("port mask", m0, 32'h0000_0003);
      check("ext mask", m1, 32'h0000_0007);
      check("ext io", {31'h0, isio}, 32'h0000_0001);
      hit(1'b1, 32'h0000_0379, 4'hF, 12'h000);
      check("base hit", {31'h0, ph}, 32'h0000_0001);
      check("ext hit", {31'h0, pe}, 32'h0000_0000);
      hit(1'b1, 32'h0000_077A, 4'hF, 12'h000);
      check("ext hit", {31'h0, pe}, 32'h0000_0001);
      check("base hit", {31'h0, ph}, 32'h0000_0000);
      hit(1'b0, 32'h0000_0778, 4'hF, 12'h000);
      test_done();
   end
endmodule
`default_nettype wire
